/* File: design/prag_guard.sv */
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// (R1) Peripheral space is sixteen 64-Mbyte regions
// (R2) Only regions 0 and 1 have registers
// (R3) Address bits 29:26 choose the region
// (R4) Region register 8 bits, read/write/execute rights
// (R5) Module guard overrides region 0 register
// (R6) Bit 7 locks register against writes
// (R7) Write to locked register errors, unchanged
// (R8) Lock cleared only by system reset
// (R9) Software keeps bits 6:4 zero
// (R10) Bits 3:0 hold the access code
// (R11) Reset gives supervisor read/write only
// (R12) Codes 0000-0111 decode without execute
// (R13) Codes 1000-1011 decode with execute
// (R14) Codes 1100-1111 decode with execute; code 1110 decodes without execute here
// (R15) Region 0 and 1 offset ranges
// (R16) Untrusted master write errors, nothing changes
// (R17) Privilege bit 0 forces user mode
// (R18) Denied access errors with no effect
module prag_guard
    import prag_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Wishbone register slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic [1:0]  wb_master_i,
    input  wire logic        wb_super_i,
    input  wire logic [3:0]  trusted_i,
    // Peripheral access check
    input  wire logic        chk_valid_i,
    input  wire logic [31:0] chk_offset_i,
    input  wire logic [1:0]  chk_master_i,
    input  wire logic        chk_super_i,
    input  wire logic        chk_read_i,
    input  wire logic        chk_write_i,
    input  wire logic        chk_fetch_i,
    input  wire logic        mod_hit_i,
    input  wire logic        mod_allow_i,
    output logic             chk_allow_o,
    output logic             chk_error_o,
    output logic             irq_o
);

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0]      region0_access_control_r;
    logic [7:0]      region1_access_control_r;
    logic [3:0]      master_privilege_bits_r;
    logic [ST_W-1:0] status_r;
    logic [ST_W-1:0] mask_r;
    logic [ST_W-1:0] status_set;
    logic            req;
    logic            wr_reg;
    logic            trusted;
    logic            locked;
    logic            known;
    logic            bad_write;
    logic            good_write;
    logic            st_read;

    assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign trusted    = trusted_i[wb_master_i] || (wb_master_i == 2'h0);
    assign known      = (wb_adr_i == REG_REGION0) || (wb_adr_i == REG_REGION1)
                        || (wb_adr_i == REG_PRIV) || (wb_adr_i == REG_STATUS);
    assign locked     = ((wb_adr_i == REG_REGION0) && region0_access_control_r[LOCK_BIT])
                        || ((wb_adr_i == REG_REGION1) && region1_access_control_r[LOCK_BIT]);
    assign wr_reg     = req && wb_we_i && wb_sel_i[0];
    assign bad_write  = req && wb_we_i && (!trusted || locked || !wb_super_i); // R7 R16
    assign good_write = wr_reg && !bad_write && known;
    assign st_read    = req && !wb_we_i && (wb_adr_i == REG_STATUS);

    // Region guard registers, reset to supervisor read/write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            region0_access_control_r <= GUARD_RESET; // R11 R8
            region1_access_control_r <= GUARD_RESET;
        end else if (good_write) begin
            if (wb_adr_i == REG_REGION0) begin
                region0_access_control_r <= (wb_dat_i[7:0] & GUARD_WR_MASK)
                                            | {region0_access_control_r[LOCK_BIT], 7'h00}; // R6 R8 R4 R9
            end
            if (wb_adr_i == REG_REGION1) begin
                region1_access_control_r <= (wb_dat_i[7:0] & GUARD_WR_MASK)
                                            | {region1_access_control_r[LOCK_BIT], 7'h00}; // R6 R8
            end
        end
    end

    // Master privilege bits and interrupt mask share the privilege word
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            master_privilege_bits_r <= PRIV_RESET;
            mask_r                  <= '0;
        end else if (good_write && (wb_adr_i == REG_PRIV)) begin
            master_privilege_bits_r <= wb_dat_i[3:0] | PRIV_RESET;
            if (wb_sel_i[1]) begin
                mask_r <= wb_dat_i[8+ST_W-1:8];
            end
        end
    end

    // Bus answer: ack or error one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req && !bad_write && known;
            wb_err_o <= req && (bad_write || !known); // R7 R16 R2
            wb_dat_o <= '0;
            if (req && !wb_we_i) begin
                unique case (wb_adr_i)
                    REG_REGION0: wb_dat_o <= {24'h0, region0_access_control_r};
                    REG_REGION1: wb_dat_o <= {24'h0, region1_access_control_r};
                    REG_PRIV:    wb_dat_o <= {20'h0, mask_r, 4'h0, master_privilege_bits_r};
                    REG_STATUS:  wb_dat_o <= {28'h0, status_r};
                    default:     wb_dat_o <= '0;
                endcase
            end
        end
    end

    // ==========================================================
    // Peripheral access check
    // ==========================================================
    logic [3:0]   region;
    logic         in_space;
    logic         eff_super;
    prag_rights_t rights;
    logic         region_ok;
    logic         allow;

    assign region    = chk_offset_i[REGION_MSB:REGION_LSB]; // R3 R1
    assign in_space  = (chk_offset_i[31:30] == 2'h0);
    assign eff_super = master_privilege_bits_r[chk_master_i] && chk_super_i; // R17

    always_comb begin
        rights = '0;
        if (region == REGION_0) begin
            rights = prag_decode(region0_access_control_r[CODE_MSB:0]); // R10 R12 R13 R14 R15
        end else if (region == REGION_1) begin
            rights = prag_decode(region1_access_control_r[CODE_MSB:0]); // R15
        end
    end

    always_comb begin
        if (eff_super) begin
            region_ok = (!chk_read_i || rights[5]) && (!chk_write_i || rights[4])
                        && (!chk_fetch_i || rights[3]);
        end else begin
            region_ok = (!chk_read_i || rights[2]) && (!chk_write_i || rights[1])
                        && (!chk_fetch_i || rights[0]);
        end
        if (!in_space) begin
            allow = 1'b0;
        end else if ((region == REGION_0) && mod_hit_i) begin
            allow = mod_allow_i; // R5
        end else begin
            allow = region_ok; // R18 R2
        end
    end

    assign chk_allow_o = chk_valid_i && allow;
    assign chk_error_o = chk_valid_i && !allow; // R18

    // ==========================================================
    // Interrupt status, cleared by reading, set wins
    // ==========================================================
    always_comb begin
        status_set            = '0;
        status_set[ST_DENY]   = chk_valid_i && !allow;
        status_set[ST_LOCKWR] = req && wb_we_i && locked && trusted;
        status_set[ST_UNTRUST]= req && wb_we_i && !trusted;
        status_set[ST_RSVD]   = req && !known;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_r <= '0;
        end else if (st_read) begin
            status_r <= status_set;
        end else begin
            status_r <= status_r | status_set;
        end
    end

    assign irq_o = |(status_r & mask_r);

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_lock_write;
        req && wb_we_i && locked;
    endsequence

    AST_LOCK_ERR: assert property (s_lock_write |=> wb_err_o && !wb_ack_o) // R7
        else $error("Locked write not errored");
    AST_LOCK_KEEP0: assert property (s_lock_write |=> $stable(region0_access_control_r)) // R7
        else $error("Locked region 0 register changed");
    AST_LOCK_STICKY: assert property (region1_access_control_r[LOCK_BIT] |=> region1_access_control_r[LOCK_BIT]) // R8
        else $error("Lock flag cleared without reset");
    AST_UNTRUST: assert property (req && wb_we_i && !trusted |=> wb_err_o ##0 $stable(master_privilege_bits_r)) // R16
        else $error("Untrusted write not blocked");
    AST_RSVD_ZERO: assert property (region0_access_control_r[6:4] == 3'h0) // R9
        else $error("Reserved bits set");
    AST_USER_FORCE: assert property (chk_valid_i && !master_privilege_bits_r[chk_master_i] && chk_write_i
                                     && (region == REGION_0) && !mod_hit_i
                                     && (region0_access_control_r[CODE_MSB:0] == 4'h0) |-> chk_error_o) // R17
        else $error("User write allowed under code 0");
    AST_NOEXEC: assert property (chk_valid_i && chk_fetch_i && in_space && (region == REGION_1)
                                 && !region1_access_control_r[CODE_MSB] |-> chk_error_o) // R12
        else $error("Fetch allowed without execute code");
    AST_RESERVED_REGION: assert property (chk_valid_i && in_space && (region > REGION_1) |-> chk_error_o) // R2
        else $error("Access to unguarded region allowed");
    AST_MOD_OVERRIDE: assert property (chk_valid_i && in_space && (region == REGION_0) && mod_hit_i
                                       |-> chk_allow_o == mod_allow_i) // R5
        else $error("Module guard not applied");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) // R4
        else $error("Ack held two cycles");

endmodule

`default_nettype wire

/* File: design/prag_pkg.sv */
package prag_pkg;

    // ==========================================================
    // Register map (byte addresses on the register bus)
    // ==========================================================
    localparam logic [3:0] REG_REGION0  = 4'h0;
    localparam logic [3:0] REG_REGION1  = 4'h4;
    localparam logic [3:0] REG_PRIV     = 4'h8;
    localparam logic [3:0] REG_STATUS   = 4'hc;
    localparam logic [3:0] REG_MASK     = 4'h0;
    localparam logic [3:0] REG_MASK_ADR = 4'h0;

    // ==========================================================
    // Region guard register fields
    // ==========================================================
    localparam int         LOCK_BIT      = 7;
    localparam int         CODE_MSB      = 3;
    localparam logic [7:0] GUARD_RESET   = 8'h00;
    localparam logic [7:0] GUARD_WR_MASK = 8'h8f;

    // ==========================================================
    // Master privilege bits
    // ==========================================================
    localparam int         NUM_MASTERS = 4;
    localparam logic [3:0] PRIV_RESET  = 4'h1;

    // ==========================================================
    // Peripheral address decode
    // ==========================================================
    localparam int         REGION_MSB = 29;
    localparam int         REGION_LSB = 26;
    localparam logic [3:0] REGION_0   = 4'h0;
    localparam logic [3:0] REGION_1   = 4'h1;

    // ==========================================================
    // Status bits
    // ==========================================================
    localparam int ST_DENY    = 0;
    localparam int ST_LOCKWR  = 1;
    localparam int ST_UNTRUST = 2;
    localparam int ST_RSVD    = 3;
    localparam int ST_W       = 4;

    // Rights vector layout {s_r, s_w, s_x, u_r, u_w, u_x}
    typedef logic [5:0] prag_rights_t;

    function automatic prag_rights_t prag_decode(input logic [3:0] code);
        unique case (code)
            4'h0:    prag_decode = 6'b110_000;
            4'h1:    prag_decode = 6'b100_000;
            4'h2:    prag_decode = 6'b100_100;
            4'h3:    prag_decode = 6'b100_000;
            4'h4:    prag_decode = 6'b110_110;
            4'h5:    prag_decode = 6'b110_100;
            4'h6:    prag_decode = 6'b110_110;
            4'h7:    prag_decode = 6'b000_000;
            4'h8:    prag_decode = 6'b111_000;
            4'h9:    prag_decode = 6'b101_000;
            4'ha:    prag_decode = 6'b101_101;
            4'hb:    prag_decode = 6'b001_000;
            4'hc:    prag_decode = 6'b111_111;
            4'hd:    prag_decode = 6'b111_101;
            4'he:    prag_decode = 6'b110_100;
            4'hf:    prag_decode = 6'b111_001;
        endcase
    endfunction

endpackage

/* File: tb/prag_master_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ======================================
// Bus master issuing peripheral accesses
module prag_master_model (
    input  wire logic        clk_sys,
    output logic             chk_valid_i,
    output logic [31:0]      chk_offset_i,
    output logic [1:0]       chk_master_i,
    output logic             chk_super_i,
    output logic [2:0]       chk_type,
    output logic             mod_hit_i,
    output logic             mod_allow_i
);
    initial begin
        chk_valid_i = 1'b0;
        chk_offset_i = 32'h0;
        chk_master_i = 2'h0;
        chk_super_i = 1'b0;
        chk_type = 3'h0;
        mod_hit_i = 1'b0;
        mod_allow_i = 1'b0;
    end

    // One access type at a time, held while valid
    task automatic issue(input logic [31:0] o, input logic [1:0] m, input logic s,
                         input logic [2:0] t, input logic h, input logic a);
        @(posedge clk_sys);
        chk_valid_i <= 1'b1;
        chk_offset_i <= o;
        chk_master_i <= m;
        chk_super_i <= s;
        chk_type <= t;
        mod_hit_i <= h;
        mod_allow_i <= a;
    endtask

    // Idle offset, type and module hit lines do not keep the last value
    task automatic idle();
        @(posedge clk_sys);
        chk_valid_i <= 1'b0;
        chk_offset_i <= ~chk_offset_i;
        chk_type <= 3'h0;
        mod_hit_i <= ~mod_hit_i;
    endtask
endmodule
`default_nettype wire

/* File: tb/prag_guard_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module prag_guard_bench;
    import prag_pkg::*;
    logic clk_sys, reset, cyc, stb, we, sup, ack, err, irq, allow, deny;
    logic [3:0] adr, sel, trusted, pv;
    logic [1:0] mst, cm;
    logic [31:0] dat, rdat, coff;
    logic [2:0] ct;
    logic cv, cs, hit, mal;
    logic [7:0] g0, g1;
    int errors, compares;
    localparam logic [5:0] DEC [16] = '{6'h30, 6'h20, 6'h24, 6'h20, 6'h36, 6'h34, 6'h36, 6'h00,
                                        6'h38, 6'h28, 6'h2d, 6'h08, 6'h3f, 6'h3d, 6'h34, 6'h39};

    prag_master_model model (.clk_sys(clk_sys), .chk_valid_i(cv), .chk_offset_i(coff),
        .chk_master_i(cm), .chk_super_i(cs), .chk_type(ct), .mod_hit_i(hit), .mod_allow_i(mal));
    prag_guard dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .wb_master_i(mst), .wb_super_i(sup), .trusted_i(trusted), .chk_valid_i(cv), .chk_offset_i(coff),
        .chk_master_i(cm), .chk_super_i(cs), .chk_read_i(ct[2]), .chk_write_i(ct[1]), .chk_fetch_i(ct[0]),
        .mod_hit_i(hit), .mod_allow_i(mal), .chk_allow_o(allow), .chk_error_o(deny), .irq_o(irq));

    always #2.5 clk_sys = ~clk_sys;

    // ======================================
    // Expected verdict
    function automatic logic [1:0] exp_chk(logic [31:0] o, logic [1:0] m, logic s, logic [2:0] t);
        logic [5:0] r;
        logic ok;
        r = DEC[o[26] ? g1[3:0] : g0[3:0]];
        if (o[31:30] != 2'h0 || o[29:26] > 4'h1) ok = 1'b0;
        else if (o[29:26] == 4'h0 && hit) ok = mal;
        else ok = |(t & ((s & pv[m]) ? r[5:3] : r[2:0]));
        return {ok, !ok};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] x);
        compares++;
        if (got !== x) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, x);
        end
    endtask

    // Wishbone cycle; x of all ones skips the data check
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] x, input logic xe);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        cmp({31'h0, err}, {31'h0, xe});
        if (!w && !xe && x !== 32'hffff_ffff) cmp(rdat, x);
        @(posedge clk_sys);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic probe(input logic [31:0] o);
        logic [1:0] m;
        logic s;
        logic [2:0] t;
        m = 2'($urandom);
        s = 1'($urandom);
        t = 3'h1 << ($urandom % 3);
        model.issue(o, m, s, t, 1'($urandom), 1'($urandom));
        #1 cmp({30'h0, allow, deny}, {30'h0, exp_chk(o, m, s, t)});
    endtask

    function automatic logic [31:0] rnd_off();
        int k;
        k = $urandom % 8;
        return {(k == 7) ? 2'h1 : 2'h0, (k < 3) ? 4'h0 : (k < 6) ? 4'h1 : 4'($urandom), 26'($urandom)};
    endfunction

    task automatic final_report();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        final_report();
    end

    // ======================================
    // Scenarios
    initial begin
        clk_sys = 0; reset = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; dat = 0;
        mst = 0; sup = 1; trusted = 4'hf; errors = 0; compares = 0; pv = 4'h1;
        pv = 4'($urandom(69)) | 4'h1;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        acc(0, REG_REGION0, 0, 4'hf, 32'h0, 0);
        acc(0, REG_PRIV, 0, 4'hf, 32'h1, 0);
        acc(0, REG_STATUS, 0, 4'hf, 32'h0, 0);
        for (int c = 0; c < 16; c++) begin
            pv = 4'($urandom) | 4'h1;
            g0 = 8'(c);
            g1 = 8'(15 - c);
            acc(1, REG_PRIV, {28'h0, pv}, 4'h1, 0, 0);
            acc(1, REG_REGION0, {24'h0, g0}, 4'h1, 0, 0);
            acc(1, REG_REGION1, {24'h0, g1}, 4'h1, 0, 0);
            probe(32'h03ff_ffff);
            probe(32'h0400_0000);
            probe(32'h07ff_ffff);
            repeat (12) probe(rnd_off());
        end
        model.idle();
        acc(0, REG_STATUS, 0, 4'hf, 32'hffff_ffff, 0);
        acc(1, REG_PRIV, 32'h1, 4'h3, 0, 0);
        acc(1, REG_REGION0, 32'h7, 4'h1, 0, 0);
        model.issue(32'h100, 0, 1, 3'h4, 0, 0);
        model.idle();
        @(posedge clk_sys);
        #1 cmp({31'h0, irq}, 32'h0);
        acc(1, REG_PRIV, 32'h101, 4'h3, 0, 0);
        #1 cmp({31'h0, irq}, 32'h1);
        acc(0, REG_STATUS, 0, 4'hf, 32'h1, 0);
        #1 cmp({31'h0, irq}, 32'h0);
        acc(0, 4'h2, 0, 4'hf, 0, 1);
        acc(0, REG_STATUS, 0, 4'hf, 32'h8, 0);
        acc(1, REG_REGION1, 32'h05, 4'h1, 0, 0);
        acc(0, REG_REGION1, 0, 4'hf, 32'h05, 0);
        acc(1, REG_REGION1, 32'h8a, 4'h1, 0, 0);
        acc(1, REG_REGION1, 32'h03, 4'h1, 0, 1);
        acc(0, REG_REGION1, 0, 4'hf, 32'h8a, 0);
        acc(0, REG_STATUS, 0, 4'hf, 32'h2, 0);
        trusted <= 4'h1;
        mst <= 2'h2;
        acc(1, REG_REGION0, 32'h4, 4'h1, 0, 1);
        mst <= 2'h0;
        sup <= 1'b0;
        acc(1, REG_REGION0, 32'h4, 4'h1, 0, 1);
        sup <= 1'b1;
        acc(0, REG_REGION0, 0, 4'hf, 32'h07, 0);
        acc(0, REG_STATUS, 0, 4'hf, 32'h4, 0);
        reset <= 1'b1;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        acc(0, REG_REGION1, 0, 4'hf, 32'h0, 0);
        acc(0, REG_PRIV, 0, 4'hf, 32'h1, 0);
        final_report();
    end
endmodule
`default_nettype wire
